// >>> logic/drive_guard.v
// Purpose: mode ownership, parameter write guard and panel supervision
// Assumes: pins synchronised here; register port on same clock
// Notes: parameter writes reach selects by register address
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "drive_guard_defines.vh"
module drive_guard #(
   parameter LOSS_CYCLES = `LOSS_CYCLES  // loss time in cycles
) (
   input  wire        clk_i,           // 50 MHz clock
   input  wire        rst_n_i,         // async reset, power-on
   input  wire [3:0]  addr_i,          // register address
   input  wire [15:0] wdata_i,         // write data
   input  wire        wr_i,            // write strobe
   input  wire        rd_i,            // read strobe
   output reg  [15:0] rdata_o,         // read data, next cycle
   input  wire        fwd_start_i,     // forward_start_input pin
   input  wire        rev_start_i,     // reverse_start_input pin
   input  wire        reset_term_i,    // reset_input_terminal pin
   input  wire        panel_present_i, // operator_panel connected
   input  wire        panel_serial_i,  // connector used for serial
   input  wire        key_panel_i,     // panel mode key
   input  wire        key_ext_i,       // external_mode_key
   input  wire        key_fwd_i,       // panel_forward_key
   input  wire        key_rev_i,       // panel_reverse_key
   input  wire        key_stop_i,      // panel stop key
   input  wire        trip_i,          // protective trip active
   input  wire        standstill_i,    // deceleration complete
   input  wire        bus_run_fwd_i,   // fieldbus forward run
   input  wire        bus_run_rev_i,   // fieldbus reverse run
   input  wire [15:0] bus_freq_i,      // fieldbus frequency
   input  wire [15:0] panel_freq_i,    // panel digital frequency
   output reg         run_fwd_o,       // forward run command
   output reg         run_rev_o,       // reverse run command
   output reg  [15:0] freq_o,          // frequency command
   output reg         decel_stop_o,    // decelerate to stop
   output reg         output_off_o,    // output shut off, coast
   output reg         duty_clear_o,    // clear thermal/brake data
   output reg         panel_stop_ind_o,// panel_stop_indication
   output reg         alarm_o,         // alarm output
   output reg         panel_loss_o,    // panel_loss_alarm_code shown
   output reg         fieldbus_mode_o, // fieldbus_mode active
   output reg         vector_ctrl_o,   // flux-vector control chosen
   output reg         reset_accept_o   // reset pulse accepted
);
   // pin synchronisers, two flops each
   reg [9:0] s1;   // first stage
   reg [9:0] s2;   // second stage
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1 <= 10'h0;
         s2 <= 10'h0;
      end else begin
         s1 <= {fwd_start_i, rev_start_i, reset_term_i, panel_present_i, panel_serial_i,
                key_panel_i, key_ext_i, key_fwd_i, key_rev_i, key_stop_i};
         s2 <= s1;
      end
   end
   wire fwd_s   = s2[9];  // synced forward start
   wire rev_s   = s2[8];  // synced reverse start
   wire rst_s   = s2[7];  // synced reset terminal
   wire pres_s  = s2[6];  // synced panel present
   wire ser_s   = s2[5];  // synced serial use
   wire kpan_s  = s2[4];  // synced panel key
   wire kext_s  = s2[3];  // synced external key
   wire kfwd_s  = s2[2];  // synced panel forward
   wire krev_s  = s2[1];  // synced panel reverse
   wire kstop_s = s2[0];  // synced stop key

   reg  [4:0]  rst_stop_sel;  // reset/disconnect/stop select
   reg  [1:0]  wr_prot_sel;   // write protect select
   reg  [1:0]  dir_inh_sel;   // direction inhibit select
   reg  [1:0]  op_mode_sel;   // operating mode select
   reg  [13:0] motor_cap;     // capacity in 0.1 kW, 9999 = V/F
   reg         panel_mode;    // panel owns commands
   reg         pstop;         // panel stop latched
   reg         start_released;// start released after stop
   reg  [4:0]  kprev;         // key edge history
   reg         rst_prev;      // reset terminal history
   wire        accept;        // write guard verdict
   wire        loss;          // panel loss from timer
   wire        running = run_fwd_o | run_rev_o;   // drive running
   // loss shuts off output only for selects 2, 3, 16 and 17
   wire        loss_sel = rst_stop_sel[4] || (rst_stop_sel[1] && !rst_stop_sel[3]);

   // write guard keyed by parameter number of the address
   reg [`PNUM_W-1:0] pnum;   // parameter number
   always @* begin
      case (addr_i)
         `ADR_RST_STOP_SEL: pnum = 8'h4b;
         `ADR_WR_PROT_SEL:  pnum = 8'h4d;
         `ADR_DIR_INH_SEL:  pnum = 8'h4e;
         `ADR_OP_MODE_SEL:  pnum = 8'h4f;
         `ADR_MOTOR_CAP:    pnum = 8'h50;
         default:           pnum = 8'h00;
      endcase
   end
   write_guard u_guard (
      .pnum_i    (pnum),
      .prot_i    (wr_prot_sel),
      .running_i (running),
      .accept_o  (accept)
   );
   loss_timer #(.LOSS_CYCLES(LOSS_CYCLES)) u_loss (
      .clk_i           (clk_i),
      .rst_n_i         (rst_n_i),
      .enable_i        (!ser_s && loss_sel),
      .panel_present_i (pres_s),
      .loss_o          (loss)
   );

   wire rst_rise  = rst_s & ~rst_prev;                        // reset pulse
   wire rst_ok    = !rst_stop_sel[0] || trip_i;
   wire do_reset  = rst_rise && rst_ok;
   wire ext_rise  = kext_s & ~kprev[3];                       // external key press
   wire pan_rise  = kpan_s & ~kprev[4];                       // panel key press
   wire stop_rise = kstop_s & ~kprev[0];                      // stop key press
   wire stop_ok   = panel_mode || rst_stop_sel >= 5'h0e;      // 14-17 both modes
   wire clear_all = wr_i && addr_i == `ADR_CLEAR_ALL && wr_prot_sel != 2'h1;

   // parameter registers and clear-all
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_stop_sel <= `RST_STOP_RESET;
         wr_prot_sel  <= `WR_PROT_RESET;
         dir_inh_sel  <= `DIR_INH_RESET;
         op_mode_sel  <= `OP_MODE_RESET;
         motor_cap    <= `MOTOR_CAP_RESET;
      end else if (clear_all) begin
         wr_prot_sel  <= `WR_PROT_RESET;                      // select kept
         dir_inh_sel  <= `DIR_INH_RESET;
         op_mode_sel  <= `OP_MODE_RESET;
         motor_cap    <= `MOTOR_CAP_RESET;
      end else if (wr_i && accept) begin
         case (addr_i)
            `ADR_RST_STOP_SEL:
               if (wdata_i[15:5] == 11'h0 &&
                   (wdata_i[4:0] <= 5'h03 ||
                    (wdata_i[4:0] >= 5'h0e && wdata_i[4:0] <= 5'h11)))
                  rst_stop_sel <= wdata_i[4:0];
            `ADR_WR_PROT_SEL:
               if (wdata_i <= 16'h0002)
                  wr_prot_sel <= wdata_i[1:0];
            `ADR_DIR_INH_SEL:
               if (wdata_i <= 16'h0002)
                  dir_inh_sel <= wdata_i[1:0];
            `ADR_OP_MODE_SEL:
               if (wdata_i <= 16'h0002)
                  op_mode_sel <= wdata_i[1:0];
            `ADR_MOTOR_CAP:
               if (wdata_i == 16'h270f ||
                   (wdata_i[13:0] >= `MOTOR_CAP_MIN && wdata_i[13:0] <= `MOTOR_CAP_MAX &&
                    wdata_i[15:14] == 2'h0))
                  motor_cap <= wdata_i[13:0];
            default: ;                                        // nothing stored
         endcase
      end
   end

   // mode ownership, panel stop and restart sequence
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         panel_mode     <= 1'b0;
         pstop          <= 1'b0;
         start_released <= 1'b0;
         kprev          <= 5'h0;
         rst_prev       <= 1'b0;
      end else begin
         kprev    <= {kpan_s, kext_s, kfwd_s, krev_s, kstop_s};
         rst_prev <= rst_s;
         case (op_mode_sel)
            2'h1:    panel_mode <= 1'b1;
            2'h2:    panel_mode <= 1'b0;
            default: begin
               if (pan_rise && !running)
                  panel_mode <= 1'b1;
               else if (ext_rise && !running && !pstop)
                  panel_mode <= 1'b0;
            end
         endcase
         if (do_reset) begin
            pstop <= 1'b0;
         end else if (stop_rise && stop_ok) begin
            pstop          <= 1'b1;
            start_released <= 1'b0;
         end else if (pstop) begin
            // restart order: standstill, release, external key
            if (standstill_i && !fwd_s && !rev_s && !bus_run_fwd_i && !bus_run_rev_i)
               start_released <= 1'b1;
            if (start_released && ext_rise)
               pstop <= 1'b0;
         end
      end
   end

   // command arbitration and status outputs
   reg want_fwd;   // requested forward run
   reg want_rev;   // requested reverse run
   always @* begin
      if (panel_mode) begin
         want_fwd = kfwd_s;
         want_rev = krev_s;
      end else begin
         want_fwd = bus_run_fwd_i | fwd_s;
         want_rev = bus_run_rev_i | rev_s;
      end
   end
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_fwd_o        <= 1'b0;
         run_rev_o        <= 1'b0;
         freq_o           <= 16'h0;
         decel_stop_o     <= 1'b0;
         output_off_o     <= 1'b1;
         duty_clear_o     <= 1'b1;
         panel_stop_ind_o <= 1'b0;
         alarm_o          <= 1'b0;
         panel_loss_o     <= 1'b0;
         fieldbus_mode_o  <= 1'b1;
         vector_ctrl_o    <= 1'b0;
         reset_accept_o   <= 1'b0;
      end else begin
         output_off_o     <= rst_s || loss;
         duty_clear_o     <= rst_s;
         decel_stop_o     <= pstop;
         panel_stop_ind_o <= pstop;
         alarm_o          <= loss || trip_i;                  // stop is not alarm
         panel_loss_o     <= loss;
         fieldbus_mode_o  <= !panel_mode;
         vector_ctrl_o    <= (motor_cap != `MOTOR_CAP_RESET);
         reset_accept_o   <= do_reset;
         freq_o           <= panel_mode ? panel_freq_i : bus_freq_i;
         if (rst_s || loss || pstop) begin
            run_fwd_o <= 1'b0;
            run_rev_o <= 1'b0;
         end else begin
            run_fwd_o <= want_fwd && !want_rev && dir_inh_sel != 2'h2;
            run_rev_o <= want_rev && !want_fwd && dir_inh_sel != 2'h1;
         end
      end
   end

   // register read port
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 16'h0;
      end else if (rd_i) begin
         case (addr_i)
            `ADR_RST_STOP_SEL: rdata_o <= {11'h0, rst_stop_sel};
            `ADR_WR_PROT_SEL:  rdata_o <= {14'h0, wr_prot_sel};
            `ADR_DIR_INH_SEL:  rdata_o <= {14'h0, dir_inh_sel};
            `ADR_OP_MODE_SEL:  rdata_o <= {14'h0, op_mode_sel};
            `ADR_MOTOR_CAP:    rdata_o <= {2'h0, motor_cap};
            `ADR_STATUS:       rdata_o <= {10'h0, loss, pstop, panel_mode,
                                           run_rev_o, run_fwd_o, accept};
            default:           rdata_o <= 16'h0;
         endcase
      end
   end
endmodule // drive_guard

// >>> inc/drive_guard_defines.vh
// Purpose: constants for the drive mode and parameter guard
// Assumes: 50 MHz clock, parameter numbers carried as 8-bit codes
// Notes: register offsets are word indices on the plain register port
// Summary of operation
// - reset pulse (even select, or odd select with trip) or power cycle clears panel stop
// - reset input shuts output, clears duty data
// - panel loss declared after over one second
// - panel absent at power-on raises no alarm
// - reset/stop select always writable, survives clear-all
// - panel stop shows indication, no alarm output
// - serial use of connector disables loss detection
// - protect 0: write only when stopped, three selects always
// - protect 2: write allowed while running
// - fixed parameter set locked while running
// - protect 1: only three selects writable
// - direction inhibit 0 both, 1 no reverse, 2 no forward
// - mode select factory 2, starts in fieldbus mode
// - mode 0: fieldbus at start, keys switch modes
// - mode 1: panel owns frequency and start
// - mode 2: fieldbus supplies frequency and start
// - capacity 9999 selects V/F, else vector
// - reset/stop select values and their meanings
// - values 14-17 panel stop in both modes
`ifndef DRIVE_GUARD_DEFINES_VH
`define DRIVE_GUARD_DEFINES_VH
`define CLK_HZ            50000000
`define LOSS_TIME_MS      1000
`define LOSS_CYCLES       ((`CLK_HZ / 1000) * `LOSS_TIME_MS)
`define ADR_RST_STOP_SEL  4'h0
`define ADR_WR_PROT_SEL   4'h1
`define ADR_DIR_INH_SEL   4'h2
`define ADR_OP_MODE_SEL   4'h3
`define ADR_MOTOR_CAP     4'h4
`define ADR_STATUS        4'h5
`define ADR_CLEAR_ALL     4'h6
`define RST_STOP_RESET    5'h0e
`define WR_PROT_RESET     2'h0
`define DIR_INH_RESET     2'h0
`define OP_MODE_RESET     2'h2
`define MOTOR_CAP_RESET   14'h270f
`define MOTOR_CAP_MIN     14'h0001
`define MOTOR_CAP_MAX     14'h004b
`define PNUM_W            8
`endif

// >>> logic/loss_timer.v
// Purpose: panel disconnection timer
// Assumes: panel_present_i is already synchronised
// Notes: absence seen since power-on never alarms
`timescale 1ns/1ps
module loss_timer #(
   parameter LOSS_CYCLES = 50000000   // cycles of absence before loss
) (
   input  wire        clk_i,            // system clock
   input  wire        rst_n_i,          // async reset, active low
   input  wire        enable_i,         // detection enabled
   input  wire        panel_present_i,  // panel seen on connector
   output reg         loss_o            // loss declared, sticky
);
   reg [31:0] count;     // absence counter
   reg        seen;      // panel has been present since power-on
   // count continuous absence, only after panel seen once
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count  <= 32'h0;
         seen   <= 1'b0;
         loss_o <= 1'b0;
      end else begin
         if (panel_present_i) begin
            seen  <= 1'b1;
            count <= 32'h0;
         end else if (enable_i && seen && !loss_o) begin
            if (count >= LOSS_CYCLES)
               loss_o <= 1'b1;
            else
               count <= count + 32'h1;
         end else if (!enable_i) begin
            count <= 32'h0;
         end
      end
   end
endmodule // loss_timer

// >>> logic/write_guard.v
// Purpose: decides whether a parameter write is accepted
// Assumes: combinational, same clock domain
// Notes: parameter codes are decimal numbers in 8 bits
`timescale 1ns/1ps
`include "drive_guard_defines.vh"
module write_guard (
   input  wire [`PNUM_W-1:0] pnum_i,     // parameter number
   input  wire [1:0]         prot_i,     // write protect select
   input  wire               running_i,  // drive running
   output reg                accept_o    // write allowed
);
   reg always_ok;   // selects writable in every state under protect 0 and 1
   reg run_locked;  // fixed set locked in operation
   // combinational accept decision
   always @* begin
      always_ok  = (pnum_i == 8'h4b) || (pnum_i == 8'h4d) || (pnum_i == 8'h4f);
      run_locked = (pnum_i == 8'h17) || (pnum_i == 8'h42) || (pnum_i == 8'h47) ||
                   (pnum_i == 8'h4f) || (pnum_i == 8'h5a) || (pnum_i == 8'h60) ||
                   (pnum_i >= 8'hb4 && pnum_i <= 8'hb7) ||
                   (pnum_i >= 8'hbe && pnum_i <= 8'hc0);
      case (prot_i)
         2'h1:    accept_o = always_ok;
         2'h2:    accept_o = !(running_i && run_locked);      // lock wins
         default: accept_o = always_ok || !running_i;
      endcase
   end
endmodule // write_guard

// >>> testbench/drive_guard_sva.sv
// Purpose: port-level checks for drive_guard
// Assumes: one clock, async active-low reset
// Notes: bound to every drive_guard instance
`timescale 1ns/1ps
module drive_guard_sva #(
   parameter LOSS_CYCLES = 20   // absence cycles before loss
) (
   input wire clk_i,            // clock
   input wire rst_n_i,          // reset, active low
   input wire wr_i,             // write strobe
   input wire reset_term_i,     // reset terminal
   input wire panel_present_i,  // panel seen
   input wire panel_serial_i,   // connector in serial use
   input wire trip_i,           // trip active
   input wire run_fwd_o,        // forward run
   input wire run_rev_o,        // reverse run
   input wire output_off_o,     // output shut off
   input wire duty_clear_o,     // duty data clear
   input wire panel_stop_ind_o, // panel stop shown
   input wire alarm_o,          // alarm output
   input wire panel_loss_o,     // panel loss
   input wire vector_ctrl_o     // vector control
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   reg [31:0] absent_cnt;  // raw cycles of panel absence
   // count absence, restart on presence
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) absent_cnt <= 32'h0;
      else if (panel_present_i) absent_cnt <= 32'h0;
      else absent_cnt <= absent_cnt + 32'h1;
   end
   property p_one_dir; !(run_fwd_o && run_rev_o); endproperty
   a_one_dir: assert property (p_one_dir) else $error("both run outputs high");
   property p_stop_quiet; panel_stop_ind_o && !panel_loss_o && !trip_i |-> !alarm_o; endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("alarm with panel stop");
   property p_stop_run; panel_stop_ind_o && $past(panel_stop_ind_o) |-> !run_fwd_o && !run_rev_o;
   endproperty
   a_stop_run: assert property (p_stop_run) else $error("run during panel stop");
   property p_term_off; $rose(reset_term_i) ##1 reset_term_i[*4] |-> output_off_o && duty_clear_o;
   endproperty
   a_term_off: assert property (p_term_off) else $error("reset input kept output");
   property p_loss_alarm; panel_loss_o && $past(panel_loss_o) |-> alarm_o; endproperty
   a_loss_alarm: assert property (p_loss_alarm) else $error("loss without alarm");
   property p_serial; panel_serial_i[*8] |=> !$rose(panel_loss_o); endproperty
   a_serial: assert property (p_serial) else $error("loss in serial use");
   property p_loss_time; $rose(panel_loss_o) |-> absent_cnt > LOSS_CYCLES; endproperty
   a_loss_time: assert property (p_loss_time) else $error("loss declared early");
   property p_vec; !wr_i && !$past(wr_i) && !$past(wr_i, 2) |=> $stable(vector_ctrl_o);
   endproperty
   a_vec: assert property (p_vec) else $error("control kind moved unasked");
   c_stop: cover property ($rose(panel_stop_ind_o));
   c_loss: cover property ($rose(panel_loss_o));
   c_vec: cover property ($rose(vector_ctrl_o));
endmodule // drive_guard_sva
bind drive_guard drive_guard_sva #(.LOSS_CYCLES(LOSS_CYCLES)) i_sva (.clk_i(clk_i),
   .rst_n_i(rst_n_i), .wr_i(wr_i), .reset_term_i(reset_term_i),
   .panel_present_i(panel_present_i), .panel_serial_i(panel_serial_i), .trip_i(trip_i),
   .run_fwd_o(run_fwd_o), .run_rev_o(run_rev_o), .output_off_o(output_off_o),
   .duty_clear_o(duty_clear_o), .panel_stop_ind_o(panel_stop_ind_o), .alarm_o(alarm_o),
   .panel_loss_o(panel_loss_o), .vector_ctrl_o(vector_ctrl_o));

// >>> testbench/far_side_model.sv
// Purpose: fieldbus master and panel operator
// Assumes: tb_top calls its tasks
// Notes: inputs change by non-blocking assignment after an edge
`timescale 1ns/1ps
module far_side_model (
   input  wire        clk_i,         // clock
   input  wire        standstill_i,  // drive at standstill
   output reg         bus_run_fwd_o, // fieldbus forward run
   output reg         bus_run_rev_o, // fieldbus reverse run
   output reg  [15:0] bus_freq_o,    // fieldbus frequency
   output reg         fwd_start_o,   // forward start terminal
   output reg         key_ext_o      // external mode key
);
   initial {bus_run_fwd_o, bus_run_rev_o, bus_freq_o, fwd_start_o, key_ext_o} = 20'h0;
   // master supplies start and frequency together
   task bus(input logic f, input logic r, input logic [15:0] hz);
      begin
         @(posedge clk_i);
         bus_run_fwd_o <= f;
         bus_run_rev_o <= r;
         bus_freq_o <= hz;
      end
   endtask
   // one press of the external mode key
   task ext_key;
      begin
         @(posedge clk_i);
         key_ext_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         key_ext_o <= 1'b0;
         repeat (6) @(posedge clk_i);
      end
   endtask
   // operator restart after a panel stop
   task restart(output logic ok);
      integer n;
      begin
         n = 0;
         while (!standstill_i && n < 50) begin  // wait for standstill
            @(posedge clk_i);
            n = n + 1;
         end
         ok = standstill_i;
         bus(1'b0, 1'b0, 16'h0000);
         fwd_start_o <= 1'b0;  // release start first
         repeat (6) @(posedge clk_i);
         ext_key;
         fwd_start_o <= 1'b1;  // start again
         repeat (6) @(posedge clk_i);
         fwd_start_o <= 1'b0;
      end
   endtask
endmodule // far_side_model

// >>> testbench/tb_top.sv
// Purpose: self-checking bench for drive_guard
// Assumes: 50 MHz clock, shortened loss time
// Notes: one sequence of register and pin scenarios
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ok;
   logic rterm = 1'b0, present = 1'b0, serial = 1'b0, trip = 1'b0, still = 1'b0;
   logic [3:0]  addr = 4'h0, key = 4'h0;  // keys: panel, fwd, rev, stop
   logic [15:0] wdata = 16'h0, pfreq = 16'h0123, d, rdata, freq, bfreq;
   logic bfwd, brev, fstart, kext, run_f, run_r, decel, off, dclr, pstop, alarm, loss, fbm, vec;
   integer num_errors = 0, num_checks = 0, n;
   always #10 clk = ~clk;
   far_side_model i_far (.clk_i(clk), .standstill_i(still), .bus_run_fwd_o(bfwd),
      .bus_run_rev_o(brev), .bus_freq_o(bfreq), .fwd_start_o(fstart), .key_ext_o(kext));
   drive_guard #(.LOSS_CYCLES(20)) i_dut (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .fwd_start_i(fstart),
      .rev_start_i(1'b0), .reset_term_i(rterm), .panel_present_i(present),
      .panel_serial_i(serial), .key_panel_i(key[0]), .key_ext_i(kext), .key_fwd_i(key[1]),
      .key_rev_i(key[2]), .key_stop_i(key[3]), .trip_i(trip), .standstill_i(still),
      .bus_run_fwd_i(bfwd), .bus_run_rev_i(brev), .bus_freq_i(bfreq), .panel_freq_i(pfreq),
      .run_fwd_o(run_f), .run_rev_o(run_r), .freq_o(freq), .decel_stop_o(decel),
      .output_off_o(off), .duty_clear_o(dclr), .panel_stop_ind_o(pstop), .alarm_o(alarm),
      .panel_loss_o(loss), .fieldbus_mode_o(fbm), .vector_ctrl_o(vec), .reset_accept_o());
   task chk(input logic [15:0] got, input logic [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wt(input integer c);
      begin
         repeat (c) @(posedge clk);
         #1;
      end
   endtask
   task wr_reg(input logic [3:0] a, input logic [15:0] v);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= v;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rd_chk(input logic [3:0] a, input logic [15:0] exp);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1;
         chk(rdata, exp);
      end
   endtask
   task press(input integer i);
      begin
         @(posedge clk);
         key[i] <= 1'b1;
         repeat (4) @(posedge clk);
         key[i] <= 1'b0;
         wt(6);
      end
   endtask
   task tend(input string s);
      $display("test %s done, errors so far %0d", s, num_errors);
   endtask
   task finish_test;
      begin
         $display("checks %0d, mismatches %0d", num_checks, num_errors);
         if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      #2000000 num_errors = num_errors + 1;
      finish_test;
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(4'h0, 16'h000e);
      rd_chk(4'h1, 16'h0000);
      rd_chk(4'h2, 16'h0000);
      rd_chk(4'h3, 16'h0002);
      rd_chk(4'h4, 16'h270f);
      wt(30);
      chk(fbm, 1'b1);
      chk(loss, 1'b0);
      wr_reg(4'h4, 16'h000a);
      wt(2);
      chk(vec, 1'b1);
      wr_reg(4'h4, 16'h004c);
      rd_chk(4'h4, 16'h000a);
      wr_reg(4'h4, 16'h270f);
      wt(2);
      chk(vec, 1'b0);
      tend("reset and capacity");
      for (d = 16'h0; d < 16'h3; d = d + 16'h1) begin
         wr_reg(4'h2, d);
         i_far.bus(1'b1, 1'b0, 16'h0bb8);
         wt(3);
         chk(run_f, d != 16'h2);
         i_far.bus(1'b0, 1'b1, 16'h0bb8);
         wt(3);
         chk(run_r, d != 16'h1);
         i_far.bus(1'b0, 1'b0, 16'h0000); // stop before next write
      end
      wr_reg(4'h2, 16'h0000);
      i_far.bus(1'b1, 1'b0, 16'h0bb8);
      wt(3);
      chk(freq, 16'h0bb8);
      wr_reg(4'h4, 16'h000a);
      rd_chk(4'h4, 16'h270f);
      wr_reg(4'h1, 16'h0002);
      wr_reg(4'h4, 16'h000a);
      rd_chk(4'h4, 16'h000a);
      wr_reg(4'h3, 16'h0001);
      rd_chk(4'h3, 16'h0002);
      chk(fbm, 1'b1);
      i_far.bus(1'b0, 1'b0, 16'h0000);
      wr_reg(4'h1, 16'h0001);
      wr_reg(4'h4, 16'h0014);
      rd_chk(4'h4, 16'h000a);
      wr_reg(4'h0, 16'h000f);
      rd_chk(4'h0, 16'h000f);
      wr_reg(4'h6, 16'h0000);
      rd_chk(4'h4, 16'h000a);
      wr_reg(4'h1, 16'h0000);
      wr_reg(4'h6, 16'h0000);
      rd_chk(4'h4, 16'h270f);
      rd_chk(4'h0, 16'h000f);
      wr_reg(4'h0, 16'h000e);
      tend("direction and write guard");
      i_far.bus(1'b1, 1'b0, 16'h0bb8);
      press(3);
      chk({pstop, alarm, run_f, decel}, 4'h9);
      still <= 1'b1;
      i_far.restart(ok);
      chk({ok, pstop}, 2'h2);
      i_far.bus(1'b1, 1'b0, 16'h0bb8);
      press(3);
      i_far.bus(1'b0, 1'b0, 16'h0000);
      rterm <= 1'b1;
      wt(6);
      chk({off, dclr}, 2'h3);
      rterm <= 1'b0;
      wt(6);
      chk({pstop, off}, 2'h0);
      wr_reg(4'h0, 16'h0002);
      i_far.bus(1'b1, 1'b0, 16'h0bb8);
      press(3);
      chk({pstop, run_f}, 2'h1);
      i_far.bus(1'b0, 1'b0, 16'h0000);
      tend("panel stop");
      wr_reg(4'h0, 16'h0010);
      present <= 1'b1;
      wt(10);
      present <= 1'b0;
      wt(15);
      chk(loss, 1'b0);
      n = 0;
      while (loss !== 1'b1 && n < 60) begin
         wt(1);
         n = n + 1;
      end
      if (n == 60) num_errors = num_errors + 1;
      if (n == 60) finish_test;
      chk({loss, alarm, off}, 3'h7);
      rst_n <= 1'b0;
      wt(3);
      rst_n <= 1'b1;
      wr_reg(4'h0, 16'h0010);
      wt(40);
      chk(loss, 1'b0);
      serial <= 1'b1;
      present <= 1'b1;
      wt(10);
      present <= 1'b0;
      wt(40);
      chk(loss, 1'b0);
      tend("panel loss");
      serial <= 1'b0;
      present <= 1'b1;
      wr_reg(4'h3, 16'h0001);
      wt(6);
      chk(fbm, 1'b0);
      key[1] <= 1'b1;
      wt(5);
      chk(run_f, 1'b1);
      chk(freq, pfreq);
      key[1] <= 1'b0;
      press(3);
      wr_reg(4'h3, 16'h0000);
      press(0);
      chk(fbm, 1'b0);
      i_far.ext_key; // first press leaves panel stop
      i_far.ext_key;
      wt(2);
      chk(fbm, 1'b1);
      tend("operating modes");
      finish_test;
   end
endmodule // tb_top
